// File: hw/dim_consts.vh
// Constants for the idle, pixel format and frame write continue command decoder.
`ifndef DIM_CONSTS_VH
`define DIM_CONSTS_VH

// Command codes taken as the first byte of a packet.
`define DIM_CMD_SW_RESET        8'h01
`define DIM_CMD_FRAME_WRITE     8'h2C
`define DIM_CMD_IDLE_EXIT       8'h38
`define DIM_CMD_IDLE_ENTRY      8'h39
`define DIM_CMD_PIXEL_FORMAT    8'h3A
`define DIM_CMD_WRITE_CONTINUE  8'h3C

// Interface pixel format register.
`define DIM_REG_PIXEL_FORMAT    8'h3A
`define DIM_PIXEL_FORMAT_RESET  8'h07
`define DIM_PIXEL_FORMAT_LSB    0
`define DIM_PIXEL_FORMAT_MSB    2

// Pixel format codes.
`define DIM_FMT_16BPP           3'h5
`define DIM_FMT_18BPP           3'h6
`define DIM_FMT_24BPP           3'h7

// Pixel word and buffering.
`define DIM_PIXEL_WIDTH         24
`define DIM_BYTES_PER_PIXEL     2'h3
`define DIM_FIFO_DEPTH          8
`define DIM_PTR_WIDTH           11

`endif

// File: hw/dim_fifo.v
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none

module dim_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg  [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg  [AW:0]      wr_ptr_ff;
  reg  [AW:0]      rd_ptr_ff;
  wire             push;
  wire             pop;
  wire             full;
  wire             empty;
  genvar           gi;

  assign empty     = (wr_ptr_ff == rd_ptr_ff);
  assign full      = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

  // Storage carries no reset, so its contents start undefined.
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_entry
      always @(posedge clk)
      begin
        if (push && (wr_ptr_ff[AW-1:0] == gi))
          mem_ff[gi] <= in_data;
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: hw/dim_pix_pack.v
// Packs received bytes into pixel words, most significant byte first.
`timescale 1ns/1ns
`default_nettype none
`include "dim_consts.vh"

module dim_pix_pack (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clear,
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  output wire        byte_ready,
  output wire        pix_valid,
  input  wire        pix_ready,
  output wire [23:0] pix_data
);

  reg  [1:0]  cnt_ff;
  reg  [15:0] hold_ff;
  wire        last;
  wire        take;

  assign last       = (cnt_ff == (`DIM_BYTES_PER_PIXEL - 2'h1));
  // The last byte of a pixel waits until the buffer can take the word.
  assign byte_ready = !last || pix_ready;
  assign take       = byte_valid && byte_ready && !clear;
  assign pix_valid  = byte_valid && last && !clear;
  assign pix_data   = {hold_ff, byte_data};

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff  <= 2'h0;
      hold_ff <= 16'h0000;
    end
    else if (clear)
    begin
      cnt_ff <= 2'h0;
    end
    else if (take)
    begin
      hold_ff <= {hold_ff[7:0], byte_data};
      cnt_ff  <= last ? 2'h0 : cnt_ff + 2'h1;
    end
  end

endmodule

`default_nettype wire

// File: hw/dim_cmd_top.v
// Idle mode, pixel format and frame write continue command decoder.
// Functional notes
// R1 - Idle exit command restores full colour
// R2 - Idle exit while off changes nothing
// R3 - Idle mode off after every reset
// R4 - Idle entry command reduces colour expression
// R5 - Idle entry while on changes nothing
// R6 - Idle and awake shows decompressed memory
// R7 - Idle primary black, secondary programmed colour
// R8 - Format parameter low bits select pixel size
// R9 - Format change visible only after memory write; the code also applies the pending format on a continue after a write
// R10 - Continue command resumes write after memory write
// R11 - Continue keeps column and page pointers
// R12 - Any other command ends frame write
// R13 - Host sends whole pixel pairs, six bytes
// R14 - Host separates commands by low power state
// R15 - Pixel words stored in arrival order
// R16 - Continue leaves other status unchanged
// R17 - Frame memory undefined after any reset
// R18 - Pixel bytes arrive most significant first
`timescale 1ns/1ns
`default_nettype none
`include "dim_consts.vh"

module dim_cmd_top #(
  parameter PW = `DIM_PTR_WIDTH,
  parameter FIFO_DEPTH = `DIM_FIFO_DEPTH,
  parameter FIFO_AW = 3
) (
  input  wire          CLOCK,
  input  wire          NRST,
  input  wire          RX_VALID,
  input  wire          RX_FIRST,
  input  wire [7:0]    RX_DATA,
  output wire          RX_READY,
  input  wire          SLEEP_OUT,
  input  wire [23:0]   IDLE_COLOR,
  input  wire [PW-1:0] COL_START,
  input  wire [PW-1:0] COL_END,
  input  wire [PW-1:0] PAGE_START,
  input  wire [PW-1:0] PAGE_END,
  output wire          FM_WR_VALID,
  input  wire          FM_WR_READY,
  output wire [23:0]   FM_WR_DATA,
  output wire [PW-1:0] FM_WR_COL,
  output wire [PW-1:0] FM_WR_PAGE,
  input  wire [23:0]   FM_SCAN_PIX,
  output wire [23:0]   DISP_PIX,
  output wire          IDLE_MODE,
  output wire          IDLE_SHOW,
  output wire [2:0]    PIXEL_FORMAT,
  output wire [2:0]    PIXEL_FORMAT_PENDING,
  output wire          WRITE_ACTIVE
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_WRITE = 2'h1;
  localparam [1:0] ST_FMT   = 2'h2;

  // The format code resets to the low bits of the register's reset byte.
  localparam [7:0]    FMT_RESET_BYTE = `DIM_PIXEL_FORMAT_RESET;
  localparam [2:0]    FMT_RESET_CODE = FMT_RESET_BYTE[`DIM_PIXEL_FORMAT_MSB:`DIM_PIXEL_FORMAT_LSB];
  localparam [PW-1:0] PTR_ONE        = {{(PW-1){1'b0}}, 1'b1};

  reg  [1:0]    state_ff;
  reg  [1:0]    nxt_state;
  reg           idle_ff;
  reg           nxt_idle;
  reg           armed_ff;
  reg           nxt_armed;
  reg  [2:0]    fmt_ff;
  reg  [2:0]    nxt_fmt;
  reg  [2:0]    act_fmt_ff;
  reg  [2:0]    nxt_act_fmt;
  reg  [PW-1:0] col_ff;
  reg  [PW-1:0] nxt_col;
  reg  [PW-1:0] page_ff;
  reg  [PW-1:0] nxt_page;
  reg  [23:0]   disp_ff;
  reg  [23:0]   nxt_disp;

  wire          fifo_in_valid;
  wire          fifo_in_ready;
  wire [23:0]   fifo_in_data;
  wire          fifo_out_valid;
  wire          pack_byte_ready;
  wire          pack_byte_valid;
  wire          cmd_take;
  wire          param_take;
  wire          fm_push;
  wire          cmd_ready;
  wire          param_ready;
  wire          write_state;
  wire          fmt_state;
  wire          fmt_param_take;
  wire [2:0]    fmt_code;
  wire          write_open;
  wire          write_resume;
  wire          col_at_end;
  wire          page_at_end;
  wire [PW-1:0] col_inc;
  wire [PW-1:0] page_inc;
  wire          idle_render;
  wire          scan_is_black;

  // A new command waits until every buffered pixel has reached memory, so
  // pointer changes never apply to pixels of the previous burst.
  assign cmd_ready       = !fifo_out_valid;
  assign write_state     = (state_ff == ST_WRITE);
  assign fmt_state       = (state_ff == ST_FMT);
  // Parameter bytes outside a write or format burst are taken and dropped.
  assign param_ready     = write_state ? pack_byte_ready : 1'b1;
  assign cmd_take        = RX_VALID && RX_FIRST && cmd_ready;
  assign param_take      = RX_VALID && !RX_FIRST;
  assign fmt_param_take  = param_take && fmt_state;
  assign fmt_code        = RX_DATA[`DIM_PIXEL_FORMAT_MSB:`DIM_PIXEL_FORMAT_LSB];
  assign pack_byte_valid = param_take && write_state;
  assign RX_READY        = RX_FIRST ? cmd_ready : param_ready;
  assign fm_push         = FM_WR_VALID && FM_WR_READY;

  // A continue with no memory write since reset has nowhere to resume, so
  // it only ends the running burst.
  assign write_open      = cmd_take && (RX_DATA == `DIM_CMD_FRAME_WRITE);
  assign write_resume    = cmd_take && (RX_DATA == `DIM_CMD_WRITE_CONTINUE) && armed_ff;

  // Pointer stepping across the write window.
  assign col_at_end      = (col_ff == COL_END);
  assign page_at_end     = (page_ff == PAGE_END);
  assign col_inc         = col_ff + PTR_ONE;
  assign page_inc        = page_ff + PTR_ONE;

  // Idle rendering applies only while the panel is awake.
  assign idle_render     = idle_ff && SLEEP_OUT;
  assign scan_is_black   = (FM_SCAN_PIX == 24'h000000);

  // Bytes of an unfinished pixel are dropped when the next command starts.
  dim_pix_pack u_pack (
    .clk        (CLOCK),
    .rst_n      (NRST),
    .clear      (cmd_take),
    .byte_valid (pack_byte_valid),
    .byte_data  (RX_DATA),
    .byte_ready (pack_byte_ready),
    .pix_valid  (fifo_in_valid),
    .pix_ready  (fifo_in_ready),
    .pix_data   (fifo_in_data)
  ); // R18

  // The buffer lets the byte link run on while frame memory stalls.
  dim_fifo #(
    .WIDTH (`DIM_PIXEL_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (NRST),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (FM_WR_READY),
    .out_data  (FM_WR_DATA)
  ); // R15

  // Command decoding and mode state.
  always @*
  begin
    nxt_state   = state_ff;
    nxt_idle    = idle_ff;
    nxt_armed   = armed_ff;
    nxt_fmt     = fmt_ff;
    nxt_act_fmt = act_fmt_ff;
    if (cmd_take)
    begin
      nxt_state = ST_IDLE; // R12
      case (RX_DATA)
        `DIM_CMD_IDLE_EXIT:
        begin
          nxt_idle = 1'b0; // R1 R2
        end
        `DIM_CMD_IDLE_ENTRY:
        begin
          nxt_idle = 1'b1; // R4 R5
        end
        `DIM_CMD_PIXEL_FORMAT:
        begin
          nxt_state = ST_FMT;
        end
        // A memory write rewinds the pointers and applies the pending format.
        `DIM_CMD_FRAME_WRITE:
        begin
          nxt_armed   = 1'b1;
          nxt_state   = ST_WRITE;
          nxt_act_fmt = fmt_ff; // R9
        end
        // A continue leaves the pointers where the last burst stopped.
        `DIM_CMD_WRITE_CONTINUE:
        begin
          if (write_resume)
          begin
            nxt_state   = ST_WRITE; // R10 R16
            nxt_act_fmt = fmt_ff; // R9
          end
        end
        // Software reset returns every mode to its power-on value.
        `DIM_CMD_SW_RESET:
        begin
          nxt_idle    = 1'b0; // R3
          nxt_armed   = 1'b0;
          nxt_fmt     = FMT_RESET_CODE;
          nxt_act_fmt = FMT_RESET_CODE;
        end
        default:
        begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
    else if (fmt_param_take)
    begin
      // Undefined codes are kept as written.
      nxt_fmt   = fmt_code; // R8
      nxt_state = ST_IDLE;
    end
  end

  // Column and page pointers: reset by memory write, kept by continue.
  always @*
  begin
    nxt_col  = col_ff;
    nxt_page = page_ff;
    if (write_open)
    begin
      nxt_col  = COL_START;
      nxt_page = PAGE_START;
    end
    else if (fm_push)
    begin
      if (col_at_end)
      begin
        nxt_col  = COL_START;
        nxt_page = page_at_end ? PAGE_START : page_inc;
      end
      else
      begin
        nxt_col = col_inc;
      end
    end
  end // R11

  // Idle rendering maps a stored zero to black and anything else to the
  // programmed secondary colour.
  always @*
  begin
    nxt_disp = FM_SCAN_PIX; // R1
    if (idle_render)
    begin
      if (scan_is_black)
        nxt_disp = 24'h000000; // R7
      else
        nxt_disp = IDLE_COLOR; // R6 R7
    end
  end

  // Every state register loads a constant on reset.
  always @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_ff   <= ST_IDLE;
      idle_ff    <= 1'b0; // R3
      armed_ff   <= 1'b0;
      fmt_ff     <= FMT_RESET_CODE;
      act_fmt_ff <= FMT_RESET_CODE;
      col_ff     <= {PW{1'b0}};
      page_ff    <= {PW{1'b0}};
      disp_ff    <= 24'h000000;
    end
    else
    begin
      state_ff   <= nxt_state;
      idle_ff    <= nxt_idle;
      armed_ff   <= nxt_armed;
      fmt_ff     <= nxt_fmt;
      act_fmt_ff <= nxt_act_fmt;
      col_ff     <= nxt_col;
      page_ff    <= nxt_page;
      disp_ff    <= nxt_disp;
    end
  end

  // Frame memory itself is outside and is never cleared by reset.
  assign FM_WR_VALID          = fifo_out_valid; // R17
  assign FM_WR_COL            = col_ff;
  assign FM_WR_PAGE           = page_ff;
  assign DISP_PIX             = disp_ff;
  assign IDLE_MODE            = idle_ff;
  assign IDLE_SHOW            = idle_render;
  assign PIXEL_FORMAT         = act_fmt_ff;
  assign PIXEL_FORMAT_PENDING = fmt_ff;
  assign WRITE_ACTIVE         = write_state;

endmodule

`default_nettype wire

// File: dv/dim_chk_assertions.sv
// Concurrent checks on the command decoder ports.
`timescale 1ns/1ns
`default_nettype none
module dim_chk #(
  parameter PW = 11
) (
  input wire logic          CLOCK,
  input wire logic          NRST,
  input wire logic          RX_VALID,
  input wire logic          RX_FIRST,
  input wire logic [7:0]    RX_DATA,
  input wire logic          RX_READY,
  input wire logic          SLEEP_OUT,
  input wire logic [23:0]   IDLE_COLOR,
  input wire logic [PW-1:0] COL_START,
  input wire logic [PW-1:0] COL_END,
  input wire logic [PW-1:0] PAGE_START,
  input wire logic          FM_WR_VALID,
  input wire logic          FM_WR_READY,
  input wire logic [PW-1:0] FM_WR_COL,
  input wire logic [PW-1:0] FM_WR_PAGE,
  input wire logic [23:0]   FM_SCAN_PIX,
  input wire logic [23:0]   DISP_PIX,
  input wire logic          IDLE_MODE,
  input wire logic          IDLE_SHOW,
  input wire logic [2:0]    PIXEL_FORMAT,
  input wire logic [2:0]    PIXEL_FORMAT_PENDING,
  input wire logic          WRITE_ACTIVE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  wire logic take = RX_VALID && RX_READY;
  wire logic cmd  = take && RX_FIRST;
  sequence fmt_param;
    cmd && RX_DATA == 8'h3A ##1 take && !RX_FIRST;
  endsequence
  a_idle_exit: assert property (cmd && RX_DATA == 8'h38 |=> !IDLE_MODE)
    else $error("idle exit ignored");
  a_idle_entry: assert property (cmd && RX_DATA == 8'h39 |=> IDLE_MODE)
    else $error("idle entry ignored");
  a_soft_reset: assert property (cmd && RX_DATA == 8'h01 |=> !IDLE_MODE && PIXEL_FORMAT_PENDING == 3'h7)
    else $error("soft reset state wrong");
  a_idle_hold: assert property (!cmd |=> $stable(IDLE_MODE))
    else $error("idle mode moved without command");
  a_idle_show: assert property (IDLE_SHOW == (IDLE_MODE && SLEEP_OUT))
    else $error("idle show mismatch");
  a_idle_colour: assert property (IDLE_SHOW |=> DISP_PIX == ($past(FM_SCAN_PIX) == 0 ? 0 : $past(IDLE_COLOR)))
    else $error("idle pixel wrong");
  a_full_colour: assert property (!IDLE_SHOW |=> DISP_PIX == $past(FM_SCAN_PIX))
    else $error("full colour pixel wrong");
  a_fmt_store: assert property (fmt_param |=> PIXEL_FORMAT_PENDING == $past(RX_DATA[2:0]))
    else $error("format code not stored");
  a_fmt_hold: assert property (!cmd |=> $stable(PIXEL_FORMAT))
    else $error("format changed without write");
  a_write_open: assert property (cmd && RX_DATA == 8'h2C |=> WRITE_ACTIVE && FM_WR_COL == COL_START
    && FM_WR_PAGE == PAGE_START && PIXEL_FORMAT == $past(PIXEL_FORMAT_PENDING))
    else $error("write open wrong");
  a_continue_keep: assert property (cmd && RX_DATA == 8'h3C && WRITE_ACTIVE |=> WRITE_ACTIVE
    && $stable(FM_WR_COL) && $stable(FM_WR_PAGE) && $stable(IDLE_MODE))
    else $error("continue moved state");
  a_write_end: assert property (cmd && RX_DATA != 8'h2C && RX_DATA != 8'h3C |=> !WRITE_ACTIVE)
    else $error("write not ended");
  a_col_step: assert property (FM_WR_VALID && FM_WR_READY && FM_WR_COL != COL_END
    |=> FM_WR_COL == $past(FM_WR_COL) + 1'b1 && $stable(FM_WR_PAGE))
    else $error("column step wrong");
endmodule
`default_nettype wire

// File: dv/dim_host.sv
// Host model that streams command and parameter bytes.
`timescale 1ns/1ns
`default_nettype none
module dim_host (
  input  wire logic       clk,
  input  wire logic       rx_ready,
  output var  logic       rx_valid,
  output var  logic       rx_first,
  output var  logic [7:0] rx_data,
  output var  logic       hung
);
  initial
  begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_data  = 8'h00;
    hung     = 1'b0;
  end
  // A byte is held until taken; the next one may follow at that same edge.
  task automatic send(input logic first, input logic [7:0] b);
    int n;
    rx_valid <= 1'b1;
    rx_first <= first;
    rx_data  <= b;
    n = 0;
    @(posedge clk);
    while (rx_ready !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 200)
      hung = 1'b1;
  endtask
  // Between bursts the data lines carry no stale value.
  task automatic idle;
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
  task automatic pixel(input logic [23:0] p);
    send(1'b0, p[23:16]);
    send(1'b0, p[15:8]);
    send(1'b0, p[7:0]);
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Testbench for the idle, format and write continue decoder.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        CLOCK        = 1'b0;
  logic        NRST         = 1'b0;
  logic        SLEEP_OUT    = 1'b1;
  logic        FM_WR_READY  = 1'b1;
  logic [23:0] IDLE_COLOR   = 24'h5A3C96;
  logic [23:0] FM_SCAN_PIX  = 24'h000000;
  logic [10:0] COL_START    = 11'h003;
  logic [10:0] COL_END      = 11'h004;
  logic [10:0] PAGE_START   = 11'h001;
  logic [10:0] PAGE_END     = 11'h002;
  wire         RX_VALID, RX_FIRST, RX_READY, FM_WR_VALID, IDLE_MODE, IDLE_SHOW, WRITE_ACTIVE, hung;
  wire [7:0]   RX_DATA;
  wire [23:0]  FM_WR_DATA, DISP_PIX;
  wire [10:0]  FM_WR_COL, FM_WR_PAGE;
  wire [2:0]   PIXEL_FORMAT, PIXEL_FORMAT_PENDING;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          n_pop      = 0;
  logic        stall_hit  = 1'b0;
  dim_cmd_top i_dut (.CLOCK(CLOCK), .NRST(NRST), .RX_VALID(RX_VALID), .RX_FIRST(RX_FIRST), .RX_DATA(RX_DATA),
    .RX_READY(RX_READY), .SLEEP_OUT(SLEEP_OUT), .IDLE_COLOR(IDLE_COLOR), .COL_START(COL_START),
    .COL_END(COL_END), .PAGE_START(PAGE_START), .PAGE_END(PAGE_END), .FM_WR_VALID(FM_WR_VALID),
    .FM_WR_READY(FM_WR_READY), .FM_WR_DATA(FM_WR_DATA), .FM_WR_COL(FM_WR_COL), .FM_WR_PAGE(FM_WR_PAGE),
    .FM_SCAN_PIX(FM_SCAN_PIX), .DISP_PIX(DISP_PIX), .IDLE_MODE(IDLE_MODE), .IDLE_SHOW(IDLE_SHOW),
    .PIXEL_FORMAT(PIXEL_FORMAT), .PIXEL_FORMAT_PENDING(PIXEL_FORMAT_PENDING), .WRITE_ACTIVE(WRITE_ACTIVE));
  dim_host i_host (.clk(CLOCK), .rx_ready(RX_READY), .rx_valid(RX_VALID), .rx_first(RX_FIRST),
    .rx_data(RX_DATA), .hung(hung));
  always #5 CLOCK = ~CLOCK;
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [23:0] pix(input int i);
    return {8'hA0 + 8'(i), 8'h50 + 8'(i), 8'h10 + 8'(i)};
  endfunction
  task automatic cmd(input logic [7:0] c);
    i_host.send(1'b1, c);
    i_host.idle;
    tick(1);
  endtask
  task automatic drain;
    for (int n = 0; FM_WR_VALID !== 1'b0; n++)
    begin
      if (n == 60)
        stall_hit = 1'b1;
      tick(1);
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Every word leaving for frame memory must match in data and address.
  always @(posedge CLOCK)
    if (FM_WR_VALID === 1'b1 && FM_WR_READY)
    begin
      chk(FM_WR_DATA, pix(n_pop), "pixel data");
      chk(FM_WR_COL, 3 + n_pop % 2, "column");
      chk(FM_WR_PAGE, 1 + n_pop / 2 % 2, "page");
      n_pop++;
    end
  // A stuck handshake or an overlong run ends the test as a failure.
  initial
  begin
    for (int n = 0; n < 20000 && hung !== 1'b1 && !stall_hit; n++)
      tick(1);
    num_errors++;
    conclude;
  end
  task automatic t_reset;
    chk(IDLE_MODE, 1'b0, "idle after reset");
    chk(PIXEL_FORMAT_PENDING, 3'h7, "format reset");
    chk(PIXEL_FORMAT, 3'h7, "format in effect reset");
    chk(WRITE_ACTIVE, 1'b0, "write after reset");
    $display("test reset done");
  endtask
  task automatic t_idle;
    cmd(8'h38);
    chk(IDLE_MODE, 1'b0, "exit while off");
    FM_SCAN_PIX <= 24'h123456;
    tick(2);
    chk(DISP_PIX, 24'h123456, "full colour");
    cmd(8'h39);
    chk(IDLE_MODE, 1'b1, "entry");
    cmd(8'h39);
    chk(IDLE_MODE, 1'b1, "entry while on");
    tick(1);
    chk(DISP_PIX, IDLE_COLOR, "secondary colour");
    FM_SCAN_PIX <= 24'h000000;
    tick(2);
    chk(DISP_PIX, 24'h000000, "primary black");
    SLEEP_OUT <= 1'b0;
    FM_SCAN_PIX <= 24'h123456;
    tick(2);
    chk(IDLE_SHOW, 1'b0, "asleep");
    chk(DISP_PIX, 24'h123456, "asleep shows memory");
    SLEEP_OUT <= 1'b1;
    cmd(8'h01);
    chk(IDLE_MODE, 1'b0, "soft reset");
    $display("test idle done");
  endtask
  task automatic t_format;
    logic [2:0] codes [4] = '{3'h6, 3'h3, 3'h7, 3'h5};
    cmd(8'h3C);
    chk(WRITE_ACTIVE, 1'b0, "continue without write");
    foreach (codes[i])
    begin
      i_host.send(1'b1, 8'h3A);
      i_host.send(1'b0, {5'h00, codes[i]});
      i_host.idle;
      tick(1);
      chk(PIXEL_FORMAT_PENDING, codes[i], "format code");
      chk(PIXEL_FORMAT, 3'h7, "format held");
    end
    $display("test format done");
  endtask
  task automatic t_write;
    logic [23:0] p;
    p = pix(8);
    FM_WR_READY <= 1'b0;
    i_host.send(1'b1, 8'h2C);
    for (int i = 0; i < 8; i++)
      i_host.pixel(pix(i));
    i_host.send(1'b0, p[23:16]);
    i_host.send(1'b0, p[15:8]);
    chk(WRITE_ACTIVE, 1'b1, "write open");
    chk(PIXEL_FORMAT, 3'h5, "format applied");
    fork
      i_host.send(1'b0, p[7:0]);
      begin
        tick(3);
        chk(RX_READY, 1'b0, "buffer full");
        FM_WR_READY <= 1'b1;
      end
    join
    i_host.idle;
    drain;
    chk(n_pop, 9, "words before continue");
    i_host.send(1'b1, 8'h3C);
    i_host.pixel(pix(9));
    i_host.pixel(pix(10));
    i_host.idle;
    tick(1);
    drain;
    chk(n_pop, 11, "words after continue");
    cmd(8'h38);
    chk(WRITE_ACTIVE, 1'b0, "write ended");
    $display("test write done");
  endtask
  initial
  begin
    tick(8);
    NRST <= 1'b1;
    tick(1);
    t_reset;
    t_idle;
    t_format;
    t_write;
    conclude;
  end
endmodule
bind dim_cmd_top dim_chk #(.PW(PW)) i_chk (.CLOCK(CLOCK), .NRST(NRST), .RX_VALID(RX_VALID), .RX_FIRST(RX_FIRST),
  .RX_DATA(RX_DATA), .RX_READY(RX_READY), .SLEEP_OUT(SLEEP_OUT), .IDLE_COLOR(IDLE_COLOR), .COL_START(COL_START),
  .COL_END(COL_END), .PAGE_START(PAGE_START), .FM_WR_VALID(FM_WR_VALID), .FM_WR_READY(FM_WR_READY),
  .FM_WR_COL(FM_WR_COL), .FM_WR_PAGE(FM_WR_PAGE), .FM_SCAN_PIX(FM_SCAN_PIX), .DISP_PIX(DISP_PIX),
  .IDLE_MODE(IDLE_MODE), .IDLE_SHOW(IDLE_SHOW), .PIXEL_FORMAT(PIXEL_FORMAT),
  .PIXEL_FORMAT_PENDING(PIXEL_FORMAT_PENDING), .WRITE_ACTIVE(WRITE_ACTIVE));
`default_nettype wire
